// ---- tb/cmd_host.sv ----
// Bus host model writing opcodes and parameters, reading results.
// Assumes one clock; every strobe lasts exactly one cycle.
`timescale 1ns/100ps
module cmd_host
  import opcode_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [15:0] rdata,
  output bus_req_t         bus
);
  initial bus = '0;

  // One write cycle, then data lines flipped
  task automatic put(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '{4'hf, ~d, 1'b0, 1'b0};
  endtask

  // One read cycle, data taken in the following cycle
  task automatic get(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    bus <= '{a, 16'h5a5a, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '{4'hf, 16'ha5a5, 1'b0, 1'b0};
    @(negedge clk);
    d = rdata;
  endtask

  // Poll storage busy before any further command
  task automatic nv_wait(output bit ok);
    logic [15:0] s;
    ok = 1'b0;
    for (int n = 0; n < 12 && !ok; n++)
    begin
      get(ADDR_NVWAIT, s);
      ok = (s[0] === 1'b0);
    end
  endtask
endmodule

// ---- tb/opcode_interp_monitor.sv ----
// Concurrent checks on the ports of the opcode interpreter.
// Assumes the package is compiled first; attached by the bind at the foot.
`timescale 1ns/100ps
module opcode_interp_monitor
  import opcode_pkg::*;
#(
  parameter int NV_CYCLES = 8
)
(
  input wire logic        clk,
  input wire logic        rst,
  input wire bus_req_t    bus,
  input wire logic [15:0] rdata,
  input wire logic        auto_load,
  input wire logic        nv_busy,
  input wire cfg_t        cfg,
  input wire logic [11:0] win_offs_applied,
  input wire logic        busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0]  last_op;
  logic [25:0] nv_run;

  // Last opcode taken while idle
  always_ff @(posedge clk)
    if (rst)
      last_op <= 8'h00;
    else if (bus.wr && bus.addr == ADDR_CMD && !busy)
      last_op <= bus.wdata[15:8];

  // Length of the current storage busy stretch
  always_ff @(posedge clk)
    if (rst || !nv_busy)
      nv_run <= 26'h0;
    else
      nv_run <= nv_run + 26'h1;

  // Opcode write, parameter write and result read steps
  sequence op_s(logic [7:0] code);
    bus.wr && bus.addr == ADDR_CMD && !busy && bus.wdata[15:8] == code;
  endsequence
  sequence param_s(logic [7:0] code);
    bus.wr && bus.addr == ADDR_CMD && busy && last_op == code;
  endsequence
  sequence result_s(logic [7:0] code);
    bus.rd && bus.addr == ADDR_CMD && busy && last_op == code;
  endsequence

  a_auto_set: assert property (op_s(OP_AUTO_USER) |=> auto_load && nv_busy)
    else $error("auto load not set");
  a_auto_clear: assert property (op_s(OP_AUTO_DEF) |=> !auto_load)
    else $error("auto load not cleared");
  a_width_load: assert property (param_s(OP_WIN_WIDTH) ##0 bus.wdata[11:0] != 12'h000
    |=> cfg.width == $past(bus.wdata[11:0])) else $error("width not loaded");
  a_search_low: assert property (param_s(OP_SEARCH) |=> cfg.search == $past(bus.wdata[11:0]))
    else $error("search margin wrong");
  a_reject_load: assert property (param_s(OP_REJECT) |=> cfg.reject == $past(bus.wdata[11:0]))
    else $error("reject margin wrong");
  a_sub_on: assert property (op_s(OP_SUB_EN) |=> cfg.sub_en)
    else $error("subtraction not enabled");
  a_sub_off: assert property (op_s(OP_SUB_DIS) |=> !cfg.sub_en)
    else $error("subtraction not disabled");
  a_offs_grid: assert property (!$past(rst) |-> win_offs_applied == $past(cfg.offs))
    else $error("applied offset not on next cycle");
  a_edge_read: assert property (result_s(OP_EDGE_READ) |=> rdata == {14'h0000, $past(cfg.edge_mode)})
    else $error("edge readback wrong");
  a_dead_read: assert property (result_s(OP_DEAD_READ) |=> rdata == {14'h0000, $past(cfg.dead)})
    else $error("dead time readback wrong");
  a_pair_guard: assert property (param_s(OP_PAIR_SET) ##0 cfg.edge_mode != EDGE_PAIR
    |=> $stable(cfg.pair_lead) && $stable(cfg.pair_wid)) else $error("pair set outside pair mode");
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
    else $error("read data outside read slot");
  a_busy_param: assert property (op_s(OP_EDGE_SET) |=> ##1 busy)
    else $error("busy not raised in parameter wait");
  a_nv_length: assert property (nv_run <= 26'(NV_CYCLES))
    else $error("storage busy held too long");
endmodule

bind opcode_interp opcode_interp_monitor #(.NV_CYCLES(NV_CYCLES)) i_mon (.clk(clk), .rst(rst), .bus(bus),
  .rdata(rdata), .auto_load(auto_load), .nv_busy(nv_busy), .cfg(cfg), .win_offs_applied(win_offs_applied),
  .busy(busy));

// ---- tb/test_tdc_trigger_edge_config_opcodes.sv ----
// Self-checking bench for the opcode interpreter.
// Assumes the package, design, host model and checker are compiled first.
`timescale 1ns/100ps
module test_tdc_trigger_edge_config_opcodes
  import opcode_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  bus_req_t    bus;
  logic [15:0] rdata;
  logic        auto_load;
  logic        nv_busy;
  cfg_t        cfg;
  logic [15:0] got;
  bit          ok;
  int          miscompares = 0;
  int          num_checks = 0;
  // Opcode, parameter, readback opcode, expected word
  logic [15:0] rows [14][4] = '{'{16'h2400, 16'h0000, 16'h2600, 16'h0000},
    '{16'h24aa, 16'h0001, 16'h26ff, 16'h0001}, '{16'h2400, 16'h0002, 16'h2600, 16'h0002},
    '{16'h2400, 16'h0003, 16'h2600, 16'h0003}, '{16'h2500, 16'h0d07, 16'h2600, 16'h0003},
    '{16'h2255, 16'hfff1, 16'h2300, 16'h0001}, '{16'h2200, 16'h0003, 16'h2300, 16'h0003},
    '{16'h2200, 16'h0000, 16'h2300, 16'h0000}, '{16'h2500, 16'h0d07, 16'h2600, 16'h0d07},
    '{16'h2500, 16'h0e02, 16'h2600, 16'h0d02}, '{16'h2800, 16'h0003, 16'h2900, 16'h0003},
    '{16'h2800, 16'h0002, 16'h2900, 16'h0002}, '{16'h2800, 16'h0001, 16'h29aa, 16'h0001},
    '{16'h2800, 16'h0000, 16'h2900, 16'h0000}};

  always #10 clk = ~clk;

  opcode_interp #(.NV_CYCLES(8)) i_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .auto_load(auto_load), .nv_busy(nv_busy), .cfg(cfg), .win_offs_applied(), .busy());
  cmd_host i_host (.clk(clk), .rdata(rdata), .bus(bus));

  // Compare and count
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Setting opcode followed by its parameter word
  task automatic set(input logic [15:0] op, input logic [15:0] p);
    i_host.put(ADDR_CMD, op);
    i_host.put(ADDR_CMD, p);
  endtask

  // Trigger readback, all five words, low 12 bits compared
  task automatic trig_read(input logic [15:0] e [5]);
    i_host.put(ADDR_CMD, 16'h16cc);
    for (int k = 0; k < 5; k++)
    begin
      i_host.get(ADDR_CMD, got);
      chk({4'h0, got[11:0]}, e[k]);
    end
  endtask

  task automatic nv_done;
    i_host.nv_wait(ok);
    if (!ok)
    begin
      miscompares++;
      summarize();
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    trig_read('{16'h0014, 16'h0fd8, 16'h0008, 16'h0004, 16'h0000});
    foreach (rows[i])
    begin
      set(rows[i][0], rows[i][1]);
      i_host.put(ADDR_CMD, rows[i][2]);
      i_host.get(ADDR_CMD, got);
      chk(got, rows[i][3]);
    end
    // Boundary values, zero width refused, upper bits dropped
    set(16'h1000, 16'h0fff);
    set(16'h10ee, 16'h0000);
    set(16'h1100, 16'h0800);
    set(16'h1200, 16'hf032);
    set(16'h1300, 16'h0001);
    i_host.put(ADDR_CMD, 16'h1400);
    trig_read('{16'h0fff, 16'h0800, 16'h0032, 16'h0001, 16'h0001});
    i_host.put(ADDR_CMD, 16'h1500);
    // Stalled host: status shows the wait, an opcode-like word is the parameter
    i_host.put(ADDR_CMD, 16'h1000);
    i_host.get(ADDR_STATUS, got);
    chk({15'h0000, got[0]}, 16'h0001);
    i_host.put(ADDR_CMD, 16'h1100);
    trig_read('{16'h0100, 16'h0800, 16'h0032, 16'h0001, 16'h0000});
    i_host.get(ADDR_CMD, got);
    chk(got, 16'h0000);
    // Auto-load selector set and cleared
    i_host.put(ADDR_CMD, 16'h0811);
    nv_done();
    chk({15'h0000, auto_load}, 16'h0001);
    i_host.put(ADDR_CMD, 16'h0900);
    nv_done();
    chk({15'h0000, auto_load}, 16'h0000);
    // Second reset in mid-run
    set(16'h2200, 16'h0001);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    trig_read('{16'h0014, 16'h0fd8, 16'h0008, 16'h0004, 16'h0000});
    i_host.put(ADDR_CMD, 16'h2300);
    i_host.get(ADDR_CMD, got);
    chk(got, 16'h0002);
    summarize();
  end
endmodule

// ---- verilog/opcode_interp.sv ----
// Command interpreter for trigger window, edge and resolution opcodes.
// Assumes a host that writes opcodes and parameters to one command port
// and reads results from it; all inputs synchronous to clk.
//
// Operation
// R1: Opcode 08 sets auto-load selector.
// R2: Opcode 09 clears auto-load selector.
// R3: Old firmware: host waits 10 ms after storage.
// R4: Setting opcode waits for one parameter word.
// R5: Opcode 10 loads 12-bit window width.
// R6: Opcode 11 loads signed window offset.
// R7: Offset applied on clock cycle grid.
// R8: Opcode 12 loads search margin, low 12 bits.
// R9: Opcode 13 loads 12-bit reject margin.
// R10: Opcode 14 enables trigger time subtraction.
// R11: Opcode 15 disables trigger time subtraction.
// R12: Opcode 16 returns five trigger words.
// R13: Opcode 22 sets edge detection mode.
// R14: Opcode 23 returns edge detection mode.
// R15: Opcode 24 sets edge-time bin.
// R16: Opcode 25 sets pair resolutions.
// R17: Pair resolution applies only in pair mode.
// R18: Opcode 26 returns resolution word.
// R19: Opcode 28 sets dead time.
// R20: Opcode 29 returns dead time.
// R21: Readback stalls until result is read.
// R22: Opcode low byte is ignored.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/100ps

module opcode_interp
  import opcode_pkg::*;
#(
  parameter int NV_CYCLES = NV_WRITE_CYC
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire bus_req_t    bus,
  output logic [15:0]      rdata,
  output logic             auto_load,
  output logic             nv_busy,
  output cfg_t             cfg,
  output logic [11:0]      win_offs_applied,
  output logic             busy
);

  typedef enum logic [1:0] {S_IDLE, S_PARAM, S_READ} state_t;

  state_t      state;
  logic [7:0]  op;
  logic [2:0]  rd_idx;
  logic [2:0]  rd_count;
  logic [25:0] nv_cnt;
  logic        cmd_wr;
  logic        cmd_rd;
  logic [15:0] next_result;
  logic        sets_param;
  logic        reads_back;
  logic        op_wr;
  logic        param_wr;
  logic        auto_user_wr;
  logic        auto_def_wr;
  logic        sub_on_wr;
  logic        sub_off_wr;
  logic        nv_start;
  logic        width_wr;
  logic        offs_wr;
  logic        search_wr;
  logic        reject_wr;
  logic        edge_wr;
  logic        bin_wr;
  logic        pair_wr;
  logic        dead_wr;

  assign cmd_wr = bus.wr && (bus.addr == ADDR_CMD);
  assign cmd_rd = bus.rd && (bus.addr == ADDR_CMD);

  // ----------------------------------------------------------------
  // Command strobes
  // ----------------------------------------------------------------
  // Opcode taken while idle, parameter taken while waiting
  assign op_wr    = cmd_wr && (state == S_IDLE);
  assign param_wr = cmd_wr && (state == S_PARAM);                // [R4]

  // Immediate opcodes, decoded on the high byte only
  assign auto_user_wr = op_wr && (bus.wdata[15:8] == OP_AUTO_USER);  // [R22]
  assign auto_def_wr  = op_wr && (bus.wdata[15:8] == OP_AUTO_DEF);
  assign sub_on_wr    = op_wr && (bus.wdata[15:8] == OP_SUB_EN);
  assign sub_off_wr   = op_wr && (bus.wdata[15:8] == OP_SUB_DIS);
  assign nv_start     = auto_user_wr || auto_def_wr;

  // Parameter word loads, keyed by the held opcode
  assign width_wr  = param_wr && (op == OP_WIN_WIDTH);
  assign offs_wr   = param_wr && (op == OP_WIN_OFFS);
  assign search_wr = param_wr && (op == OP_SEARCH);
  assign reject_wr = param_wr && (op == OP_REJECT);
  assign edge_wr   = param_wr && (op == OP_EDGE_SET);
  assign bin_wr    = param_wr && (op == OP_BIN_SET);
  assign pair_wr   = param_wr && (op == OP_PAIR_SET);
  assign dead_wr   = param_wr && (op == OP_DEAD_SET);

  // ----------------------------------------------------------------
  // Opcode classification
  // ----------------------------------------------------------------
  // Decode on high byte only
  always_comb
  begin
    sets_param = 1'b0;
    reads_back = 1'b0;
    case (bus.wdata[15:8])                                  // [R22]
      OP_WIN_WIDTH, OP_WIN_OFFS, OP_SEARCH, OP_REJECT,
      OP_EDGE_SET, OP_BIN_SET, OP_PAIR_SET, OP_DEAD_SET:
        sets_param = 1'b1;
      OP_TRIG_READ, OP_EDGE_READ, OP_RES_READ, OP_DEAD_READ:
        reads_back = 1'b1;
      default:
        sets_param = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Opcode, parameter wait and readback wait
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state    <= S_IDLE;
      op       <= 8'h00;
      rd_idx   <= 3'h0;
      rd_count <= 3'h0;
    end
    else
    begin
      case (state)
        S_IDLE:
          if (cmd_wr)
          begin
            op     <= bus.wdata[15:8];                      // [R22]
            rd_idx <= 3'h0;
            if (sets_param)
              state <= S_PARAM;                             // [R4]
            else if (reads_back)
            begin
              state    <= S_READ;                           // [R21]
              rd_count <= (bus.wdata[15:8] == OP_TRIG_READ) ? 3'(NUM_TRIG_WORDS) : 3'h1;
            end
          end
        S_PARAM:
          if (cmd_wr)
            state <= S_IDLE;                                // [R4]
        S_READ:
          if (cmd_rd)
          begin
            if (rd_idx == rd_count - 3'h1)
              state <= S_IDLE;                              // [R21]
            rd_idx <= rd_idx + 3'h1;                        // [R12]
          end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Trigger window settings
  // ----------------------------------------------------------------
  // Match window width, zero refused
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg.width <= WIDTH_RST;
    else if (width_wr && bus.wdata[11:0] != 12'h000)
      cfg.width <= bus.wdata[11:0];                         // [R5]
  end

  // Window offset, stored raw as a signed count
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg.offs <= OFFS_RST;
    else if (offs_wr)
      cfg.offs <= bus.wdata[11:0];                          // [R6]
  end

  // Extra search margin, bits 12 to 15 dropped
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg.search <= SEARCH_RST;
    else if (search_wr)
      cfg.search <= bus.wdata[11:0];                        // [R8]
  end

  // Reject margin, zero at the window start
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg.reject <= REJECT_RST;
    else if (reject_wr)
      cfg.reject <= bus.wdata[11:0];                        // [R9]
  end

  // ----------------------------------------------------------------
  // Trigger time subtraction
  // ----------------------------------------------------------------
  // Set and cleared by immediate opcodes
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg.sub_en <= 1'b0;
    else if (sub_on_wr)
      cfg.sub_en <= 1'b1;                                   // [R10]
    else if (sub_off_wr)
      cfg.sub_en <= 1'b0;                                   // [R11]
  end

  // ----------------------------------------------------------------
  // Edge detection and resolution
  // ----------------------------------------------------------------
  // Edge detection mode
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg.edge_mode <= EDGE_RST;
    else if (edge_wr)
      cfg.edge_mode <= bus.wdata[1:0];                      // [R13]
  end

  // Edge-time bin for single-edge modes
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg.bin <= BIN_RST;
    else if (bin_wr)
      cfg.bin <= bus.wdata[1:0];                            // [R15]
  end

  // Pair leading-time resolution, pair mode only
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg.pair_lead <= PAIR_LEAD_RST;
    else if (pair_wr && cfg.edge_mode == EDGE_PAIR)           // [R17]
      cfg.pair_lead <= bus.wdata[2:0];                      // [R16]
  end

  // Pair width resolution, the two top codes refused
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg.pair_wid <= PAIR_WID_RST;
    else if (pair_wr && cfg.edge_mode == EDGE_PAIR && bus.wdata[PAIR_WID_LSB+3:PAIR_WID_LSB] <= PAIR_WID_MAX)
      cfg.pair_wid <= bus.wdata[PAIR_WID_LSB+3:PAIR_WID_LSB];  // [R16]
  end

  // ----------------------------------------------------------------
  // Dead time between hits
  // ----------------------------------------------------------------
  // Per-channel dead time code
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg.dead <= DEAD_RST;
    else if (dead_wr)
      cfg.dead <= bus.wdata[1:0];                           // [R19]
  end

  // ----------------------------------------------------------------
  // Applied offset
  // ----------------------------------------------------------------
  // Offset taken on the clock grid, one cycle behind the store
  always_ff @(posedge clk)
  begin
    if (rst)
      win_offs_applied <= OFFS_RST;
    else
      win_offs_applied <= cfg.offs;                         // [R7]
  end

  // ----------------------------------------------------------------
  // Auto-load selector and storage busy time
  // ----------------------------------------------------------------
  // Selector level that the next power-on or global reset follows
  always_ff @(posedge clk)
  begin
    if (rst)
      auto_load <= 1'b0;
    else if (auto_user_wr)
      auto_load <= 1'b1;                                    // [R1]
    else if (auto_def_wr)
      auto_load <= 1'b0;                                    // [R2]
  end

  // Storage write time, reloaded by either selector opcode
  always_ff @(posedge clk)
  begin
    if (rst)
      nv_cnt <= 26'h0;
    else if (nv_start)
      nv_cnt <= 26'(NV_CYCLES);                             // [R3]
    else if (nv_cnt != 26'h0)
      nv_cnt <= nv_cnt - 26'h1;
  end

  // Busy indicator drops with the last count
  always_ff @(posedge clk)
  begin
    if (rst)
      nv_busy <= 1'b0;
    else if (nv_start)
      nv_busy <= 1'b1;                                      // [R3]
    else if (nv_cnt != 26'h0)
      nv_busy <= (nv_cnt != 26'h1);
  end

  // ----------------------------------------------------------------
  // Result selection and read port
  // ----------------------------------------------------------------
  // Result word for the current readback step
  always_comb
  begin
    next_result = 16'h0000;
    case (op)
      OP_TRIG_READ:                                         // [R12]
        case (rd_idx)
          3'h0:    next_result = {4'h0, cfg.width};
          3'h1:    next_result = {4'h0, cfg.offs};
          3'h2:    next_result = {4'h0, cfg.search};
          3'h3:    next_result = {4'h0, cfg.reject};
          default: next_result = {15'h0000, cfg.sub_en};
        endcase
      OP_EDGE_READ:
        next_result = {14'h0000, cfg.edge_mode};            // [R14]
      OP_RES_READ:
        if (cfg.edge_mode == EDGE_PAIR)                     // [R18]
          next_result = {4'h0, cfg.pair_wid, 5'h00, cfg.pair_lead};
        else
          next_result = {14'h0000, cfg.bin};
      OP_DEAD_READ:
        next_result = {14'h0000, cfg.dead};                 // [R20]
      default:
        next_result = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Read data one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= 16'h0000;
    else if (bus.rd)
    begin
      case (bus.addr)
        ADDR_CMD:    rdata <= (state == S_READ) ? next_result : 16'h0000;
        ADDR_STATUS: rdata <= {13'h0000, rd_idx[0], state == S_READ, state == S_PARAM};
        ADDR_NVWAIT: rdata <= {14'h0000, auto_load, nv_busy};
        default:     rdata <= 16'h0000;
      endcase
    end
    else
      rdata <= 16'h0000;
  end

  // ----------------------------------------------------------------
  // Interpreter busy view
  // ----------------------------------------------------------------
  // Busy flag for status view
  always_ff @(posedge clk)
  begin
    if (rst)
      busy <= 1'b0;
    else
      busy <= (state != S_IDLE);
  end

endmodule

// ---- verilog/opcode_pkg.sv ----
// Package for the trigger, edge and resolution opcode interpreter.
// Assumes a single 50 MHz clock domain and a 16-bit command port.
package opcode_pkg;

  // ----------------------------------------------------------------
  // Register port offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CMD    = 4'h0;  // Opcode / parameter / result port
  localparam logic [3:0] ADDR_STATUS = 4'h4;  // Interpreter status
  localparam logic [3:0] ADDR_NVWAIT = 4'h8;  // Nonvolatile busy indicator

  // ----------------------------------------------------------------
  // Opcode high bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_AUTO_USER  = 8'h08;
  localparam logic [7:0] OP_AUTO_DEF   = 8'h09;
  localparam logic [7:0] OP_WIN_WIDTH  = 8'h10;
  localparam logic [7:0] OP_WIN_OFFS   = 8'h11;
  localparam logic [7:0] OP_SEARCH     = 8'h12;
  localparam logic [7:0] OP_REJECT     = 8'h13;
  localparam logic [7:0] OP_SUB_EN     = 8'h14;
  localparam logic [7:0] OP_SUB_DIS    = 8'h15;
  localparam logic [7:0] OP_TRIG_READ  = 8'h16;
  localparam logic [7:0] OP_EDGE_SET   = 8'h22;
  localparam logic [7:0] OP_EDGE_READ  = 8'h23;
  localparam logic [7:0] OP_BIN_SET    = 8'h24;
  localparam logic [7:0] OP_PAIR_SET   = 8'h25;
  localparam logic [7:0] OP_RES_READ   = 8'h26;
  localparam logic [7:0] OP_DEAD_SET   = 8'h28;
  localparam logic [7:0] OP_DEAD_READ  = 8'h29;

  // ----------------------------------------------------------------
  // Reset values, pair mode code and pair width limit
  // ----------------------------------------------------------------
  localparam logic [11:0] WIDTH_RST   = 12'h014;
  localparam logic [11:0] OFFS_RST    = 12'hfd8;
  localparam logic [11:0] SEARCH_RST  = 12'h008;
  localparam logic [11:0] REJECT_RST  = 12'h004;
  localparam logic [1:0]  EDGE_RST    = 2'h2;
  localparam logic [1:0]  EDGE_PAIR   = 2'h0;
  localparam logic [1:0]  BIN_RST     = 2'h3;
  localparam logic [2:0]  PAIR_LEAD_RST = 3'h0;
  localparam logic [3:0]  PAIR_WID_RST  = 4'h0;
  localparam logic [3:0]  PAIR_WID_MAX  = 4'hd;
  localparam logic [1:0]  DEAD_RST    = 2'h0;

  // ----------------------------------------------------------------
  // Field position and trigger word count
  // ----------------------------------------------------------------
  localparam int PAIR_WID_LSB = 8;
  localparam int NUM_TRIG_WORDS = 5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 50;
  localparam int NV_WRITE_MS   = 10;
  localparam int NV_WRITE_CYC  = NV_WRITE_MS * 1000 * CLK_MHZ;

  // Command port bundle
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  // Stored configuration
  typedef struct packed {
    logic [11:0] width;
    logic [11:0] offs;
    logic [11:0] search;
    logic [11:0] reject;
    logic        sub_en;
    logic [1:0]  edge_mode;
    logic [1:0]  bin;
    logic [2:0]  pair_lead;
    logic [3:0]  pair_wid;
    logic [1:0]  dead;
  } cfg_t;

endpackage
